// ==== design/flash_cmd_consts.svh ====
// Opcodes, pin layout and timing counts for the latch and identification commands
// Overview of operation
// - A complete latch-set opcode ended by chip select rising sets the latch.
// - These opcodes arrive as eight single-line clocks or two quad clocks.
// - Single-line opcodes use only line zero; the upper three lines are ignored.
// - A complete latch-clear opcode ended by chip select rising clears the latch.
// - Power-up, reset pin low and soft reset completion clear the latch.
// - Completion of any program, erase, status write or suspend clears the latch.
// - Completion of any protection, lock, boot or address write clears the latch.
// - Three-byte identification is shifted out on one line, single-line mode only.
// - Chip select high ends any read; the output stops driving at once.
// - During program or erase the identification opcode is not decoded.
// - Release ends immediately unless in deep power-down, then after recovery time.
// - Reset pin low takes the device out of deep power-down.
// - Signature read returns one legacy signature byte.
// - Release and signature read work in deep power-down, never while busy.
// - The signature byte repeats while clocks continue; host reads one at least.
// - Maker/device read takes opcode, two dummy bytes, one address; MSB first out.
// - Address zero gives maker byte first, address one gives device byte first.
// - Maker and device bytes alternate until chip select rises.
// - The latch is volatile and shows as status bit one.
`ifndef FLASH_CMD_CONSTS_SVH
`define FLASH_CMD_CONSTS_SVH

`define OPC_LATCH_SET 8'h06
`define OPC_LATCH_CLEAR 8'h04
`define OPC_IDENT_READ 8'h9F
`define OPC_SIGNATURE 8'hAB
`define OPC_MAKER_DEV 8'h90

`define ADDR_DEVICE_FIRST 8'h01
`define MAKER_ADDR_BITS 5'd24
`define SR_BUSY_BIT 0
`define SR_LATCH_BIT 1

`define PIN_WIDTH 7
`define PIN_IDLE 7'h60
`define PIN_RESET 6
`define PIN_CS 5
`define PIN_SCLK 4

`define OE_SINGLE 4'hD
`define OE_QUAD 4'h0
`define OE_OFF 4'hF

`define REF_CLK_NS 100
`define REL_RECOVERY_NS 10000
`define REL_RECOVERY_CYC (`REL_RECOVERY_NS / `REF_CLK_NS)

`endif

// ==== design/flash_cmd_pkg.sv ====
// Types shared by the latch and identification command logic
package flash_cmd_pkg;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_OPCODE = 6'h02,
      ST_ADDR = 6'h04,
      ST_DONE = 6'h08,
      ST_OUT = 6'h10,
      ST_DISCARD = 6'h20
   } cmd_state_t;

   typedef enum logic [3:0] {
      PEND_NONE = 4'h1,
      PEND_SET = 4'h2,
      PEND_CLEAR = 4'h4,
      PEND_RELEASE = 4'h8
   } pending_t;

   typedef enum logic [2:0] {
      OUT_IDENT = 3'h1,
      OUT_SIG = 3'h2,
      OUT_MAKER = 3'h4
   } out_kind_t;

endpackage : flash_cmd_pkg

// ==== design/pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic clk, // sampling clock
   input wire logic rst, // synchronous reset, high
   input wire logic [WIDTH-1:0] pins_in, // raw pin levels
   output logic [WIDTH-1:0] pins_out // filtered levels
);

   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] filt_q;

   if (WIDTH < 1) begin : g_bad_width
      $error("pin_sync needs at least one pin");
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
      end else begin
         s1_q <= pins_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A level counts only once stages two and three agree
   for (genvar i = 0; i < WIDTH; i++) begin : g_filt
      always_ff @(posedge clk) begin
         if (rst) begin
            filt_q[i] <= INIT[i];
         end else if (s2_q[i] == s3_q[i]) begin
            filt_q[i] <= s2_q[i];
         end
      end
   end

   assign pins_out = filt_q;

endmodule : pin_sync

// ==== design/write_latch_and_id_commands.sv ====
// Write-permission latch and identification command interpreter
`timescale 1ns/100ps
`include "flash_cmd_consts.svh"
module write_latch_and_id_commands import flash_cmd_pkg::*; #(
   parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
   parameter logic [7:0] MEM_TYPE = 8'h3C, // arbitrary value
   parameter logic [7:0] MEM_DENSITY = 8'h21, // arbitrary value
   parameter logic [7:0] SIGNATURE_ID = 8'h47, // arbitrary value
   parameter logic [7:0] DEVICE_ID = 8'h47, // arbitrary value
   parameter int unsigned RECOVERY_CYC = `REL_RECOVERY_CYC
) (
   input wire logic ref_clk, // 10 MHz system clock
   input wire logic rst, // synchronous reset, high
   input wire logic cs_n, // chip select pin
   input wire logic sclk, // serial clock pin
   input wire logic [3:0] sio_in, // data lines in
   output logic [3:0] sio_out, // data lines out
   output logic [3:0] sio_oe_n, // data line enables, low drives
   input wire logic reset_pin_n, // hardware reset pin
   input wire logic quad_command_mode, // quad opcode mode
   input wire logic operation_busy_flag, // program or erase running
   input wire logic write_op_done, // pulse: content-changing command done
   input wire logic soft_reset_done, // pulse: software reset done
   input wire logic powerdown_enter, // pulse: enter deep power-down
   output logic write_permission_latch, // latch state
   output logic [1:0] status_low, // status bits one and zero
   output logic deep_powerdown, // in deep power-down
   output logic standby // deselected and ready
);

   // ****************************************
   // Pin sampling and edge finding
   // ****************************************
   localparam int REC_BOUND = RECOVERY_CYC + 2;

   if (RECOVERY_CYC < 1 || RECOVERY_CYC > 998) begin : g_bad_recovery
      $error("recovery count must lie in 1..998");
   end

   logic [`PIN_WIDTH-1:0] pins_f;
   logic cs_f;
   logic sclk_f;
   logic [3:0] sio_f;
   logic hw_reset;
   logic sclk_prev_q;
   logic cs_prev_q;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_rise;

   pin_sync #(
      .WIDTH(`PIN_WIDTH),
      .INIT(`PIN_IDLE)
   ) u_pin_sync (
      .clk(ref_clk),
      .rst(rst),
      .pins_in({reset_pin_n, cs_n, sclk, sio_in}),
      .pins_out(pins_f)
   );

   assign cs_f = pins_f[`PIN_CS];
   assign sclk_f = pins_f[`PIN_SCLK];
   assign sio_f = pins_f[3:0];
   assign hw_reset = ~pins_f[`PIN_RESET];

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sclk_prev_q <= 1'b0;
         cs_prev_q <= 1'b1;
      end else begin
         sclk_prev_q <= sclk_f;
         cs_prev_q <= cs_f;
      end
   end

   assign sclk_rise = sclk_f & ~sclk_prev_q & ~cs_f;
   assign sclk_fall = ~sclk_f & sclk_prev_q & ~cs_f;
   assign cs_rise = cs_f & ~cs_prev_q;

   // ****************************************
   // Command decode
   // ****************************************
   cmd_state_t state_q;
   pending_t pend_q;
   out_kind_t kind_q;
   logic quad_q;
   logic [4:0] bit_cnt_q;
   logic [7:0] shin_q;
   logic [7:0] shin_next;
   logic opc_last;
   logic addr_last;
   logic dpd_q;
   logic [15:0] recov_q;
   logic latch_q;
   cmd_state_t dec_state;
   pending_t dec_pend;
   out_kind_t dec_kind;

   // Upper lines are not looked at in single-line mode
   assign shin_next = quad_q ? {shin_q[3:0], sio_f} : {shin_q[6:0], sio_f[0]};
   assign opc_last = quad_q ? (bit_cnt_q == 5'd1) : (bit_cnt_q == 5'd7);
   assign addr_last = (state_q == ST_ADDR) && (bit_cnt_q == `MAKER_ADDR_BITS - 5'd1);

   always_comb begin
      dec_state = ST_DISCARD;
      dec_pend = PEND_NONE;
      dec_kind = OUT_IDENT;
      // Nothing is decoded while a program or erase runs
      if (!operation_busy_flag) begin
         if (shin_next == `OPC_SIGNATURE) begin
            dec_state = ST_OUT;
            dec_kind = OUT_SIG;
            dec_pend = PEND_RELEASE;
         end else if (!dpd_q) begin
            if (shin_next == `OPC_LATCH_SET) begin
               dec_state = ST_DONE;
               dec_pend = PEND_SET;
            end else if (shin_next == `OPC_LATCH_CLEAR) begin
               dec_state = ST_DONE;
               dec_pend = PEND_CLEAR;
            end else if (shin_next == `OPC_IDENT_READ && !quad_q) begin
               dec_state = ST_OUT;
            end else if (shin_next == `OPC_MAKER_DEV && !quad_q) begin
               dec_state = ST_ADDR;
               dec_kind = OUT_MAKER;
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst || hw_reset) begin
         state_q <= ST_IDLE;
         pend_q <= PEND_NONE;
         kind_q <= OUT_IDENT;
         quad_q <= 1'b0;
         bit_cnt_q <= 5'd0;
         shin_q <= 8'h00;
      end else if (cs_f) begin
         state_q <= ST_IDLE;
         pend_q <= PEND_NONE;
         quad_q <= quad_command_mode;
         bit_cnt_q <= 5'd0;
         shin_q <= 8'h00;
      end else if (sclk_rise) begin
         unique case (state_q)
            ST_IDLE, ST_OPCODE: begin
               shin_q <= shin_next;
               bit_cnt_q <= bit_cnt_q + 5'd1;
               state_q <= ST_OPCODE;
               if (opc_last) begin
                  state_q <= dec_state;
                  pend_q <= dec_pend;
                  kind_q <= dec_kind;
                  bit_cnt_q <= 5'd0;
               end
            end
            ST_ADDR: begin
               shin_q <= shin_next;
               bit_cnt_q <= bit_cnt_q + 5'd1;
               if (addr_last) begin
                  state_q <= ST_OUT;
               end
            end
            ST_DONE: begin
               state_q <= ST_DISCARD;
               pend_q <= PEND_NONE;
            end
            ST_OUT, ST_DISCARD: begin
               state_q <= state_q;
            end
         endcase
      end else if (state_q == ST_IDLE) begin
         state_q <= ST_OPCODE;
      end
   end

   // ****************************************
   // Identification output
   // ****************************************
   logic exec_set;
   logic exec_clear;
   logic exec_release;
   logic load_out;
   out_kind_t load_kind;
   logic [1:0] start_sel;
   logic [7:0] shout_q;
   logic [1:0] byte_sel_q;
   logic [2:0] out_cnt_q;
   logic [3:0] sio_out_q;
   logic drive_q;
   logic last_out;

   function automatic logic [7:0] id_byte(input out_kind_t k, input logic [1:0] sel);
      logic [7:0] b;
      b = SIGNATURE_ID;
      if (k == OUT_IDENT) begin
         b = (sel == 2'd0) ? MAKER_ID : ((sel == 2'd1) ? MEM_TYPE : MEM_DENSITY);
      end else if (k == OUT_MAKER) begin
         b = (sel == 2'd0) ? MAKER_ID : DEVICE_ID;
      end
      return b;
   endfunction : id_byte

   function automatic logic [1:0] next_sel(input out_kind_t k, input logic [1:0] sel);
      logic [1:0] n;
      n = 2'd0;
      if (k == OUT_IDENT) begin
         n = (sel == 2'd2) ? 2'd0 : sel + 2'd1;
      end else if (k == OUT_MAKER) begin
         n = {1'b0, ~sel[0]};
      end
      return n;
   endfunction : next_sel

   assign exec_set = cs_rise && (state_q == ST_DONE) && (pend_q == PEND_SET);
   assign exec_clear = cs_rise && (state_q == ST_DONE) && (pend_q == PEND_CLEAR);
   assign exec_release = cs_rise && (state_q == ST_OUT) && (pend_q == PEND_RELEASE);

   assign load_out = sclk_rise && (addr_last ||
      ((state_q == ST_IDLE || state_q == ST_OPCODE) && opc_last && dec_state == ST_OUT));
   assign load_kind = (state_q == ST_ADDR) ? kind_q : dec_kind;
   // Address one starts with the device byte
   assign start_sel = (addr_last && shin_next == `ADDR_DEVICE_FIRST) ? 2'd1 : 2'd0;
   assign last_out = quad_q ? (out_cnt_q == 3'd1) : (out_cnt_q == 3'd7);

   always_ff @(posedge ref_clk) begin
      if (rst || hw_reset || cs_f) begin
         drive_q <= 1'b0;
         sio_out_q <= 4'h0;
         out_cnt_q <= 3'd0;
         byte_sel_q <= 2'd0;
         shout_q <= 8'h00;
      end else if (load_out) begin
         shout_q <= id_byte(load_kind, start_sel);
         byte_sel_q <= start_sel;
         out_cnt_q <= 3'd0;
      end else if (sclk_fall && state_q == ST_OUT) begin
         // Falling edge presents the next bits, MSB first
         drive_q <= 1'b1;
         sio_out_q <= quad_q ? shout_q[7:4] : {2'b00, shout_q[7], 1'b0};
         if (last_out) begin
            // Bytes follow in a ring while clocks continue
            shout_q <= id_byte(kind_q, next_sel(kind_q, byte_sel_q));
            byte_sel_q <= next_sel(kind_q, byte_sel_q);
            out_cnt_q <= 3'd0;
         end else begin
            shout_q <= quad_q ? {shout_q[3:0], 4'h0} : {shout_q[6:0], 1'b0};
            out_cnt_q <= out_cnt_q + 3'd1;
         end
      end
   end

   assign sio_out = sio_out_q;
   assign sio_oe_n = drive_q ? (quad_q ? `OE_QUAD : `OE_SINGLE) : `OE_OFF;

   // ****************************************
   // Latch and power state
   // ****************************************
   // A set landing with a completion clear wins
   always_ff @(posedge ref_clk) begin
      if (rst || hw_reset) begin
         latch_q <= 1'b0;
      end else if (exec_set) begin
         latch_q <= 1'b1;
      end else if (exec_clear) begin
         latch_q <= 1'b0;
      end else if (write_op_done || soft_reset_done) begin
         latch_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst || hw_reset) begin
         dpd_q <= 1'b0;
         recov_q <= 16'd0;
      end else if (recov_q != 16'd0) begin
         recov_q <= recov_q - 16'd1;
         if (recov_q == 16'd1) begin
            dpd_q <= 1'b0;
         end
      end else if (exec_release && dpd_q) begin
         recov_q <= RECOVERY_CYC[15:0];
      end else if (powerdown_enter) begin
         dpd_q <= 1'b1;
      end
   end

   assign write_permission_latch = latch_q;
   assign status_low = {latch_q, operation_busy_flag};
   assign deep_powerdown = dpd_q;
   assign standby = cs_f && !dpd_q && !operation_busy_flag;

   // ****************************************
   // Checks
   // ****************************************
   a_latch_set_done: assert property (@(posedge ref_clk) disable iff (rst)
      exec_set && !hw_reset |=> write_permission_latch && status_low[`SR_LATCH_BIT])
      else $error("latch not set after set command");

   a_latch_clear_done: assert property (@(posedge ref_clk) disable iff (rst)
      exec_clear |=> !write_permission_latch)
      else $error("latch not cleared after clear command");

   a_reset_pin_clears: assert property (@(posedge ref_clk) disable iff (rst)
      hw_reset |=> !write_permission_latch)
      else $error("reset pin did not clear latch");

   a_reset_wakes_up: assert property (@(posedge ref_clk) disable iff (rst)
      hw_reset |=> !deep_powerdown)
      else $error("reset pin did not leave deep power-down");

   a_completion_clears: assert property (@(posedge ref_clk) disable iff (rst)
      (write_op_done || soft_reset_done) && !exec_set |=> !write_permission_latch)
      else $error("completion did not clear latch");

   a_quad_opcode_len: assert property (@(posedge ref_clk) disable iff (rst)
      sclk_rise && quad_q && state_q == ST_OPCODE && bit_cnt_q == 5'd1 && !hw_reset
      |=> state_q != ST_OPCODE)
      else $error("quad opcode not finished after two clocks");

   a_busy_no_decode: assert property (@(posedge ref_clk) disable iff (rst)
      sclk_rise && opc_last && operation_busy_flag && !hw_reset
      && (state_q == ST_OPCODE || state_q == ST_IDLE) |=> state_q == ST_DISCARD)
      else $error("opcode decoded while busy");

   a_late_clock_drops: assert property (@(posedge ref_clk) disable iff (rst)
      state_q == ST_DONE && sclk_rise && !hw_reset |=> state_q == ST_DISCARD ##0 !exec_set)
      else $error("latch command kept after extra clock");

   a_deselect_stops: assert property (@(posedge ref_clk) disable iff (rst)
      cs_rise |=> sio_oe_n == `OE_OFF)
      else $error("output still driven after deselect");

   a_single_line_out: assert property (@(posedge ref_clk) disable iff (rst)
      !quad_q && sio_oe_n != `OE_OFF |-> sio_oe_n == `OE_SINGLE && sio_out[3] == 1'b0)
      else $error("single-line read uses wrong lines");

   a_msb_first: assert property (@(posedge ref_clk) disable iff (rst)
      sclk_fall && state_q == ST_OUT && !quad_q && !hw_reset && !load_out
      |=> sio_out[1] == $past(shout_q[7]))
      else $error("output bit is not the byte MSB");

   a_device_first: assert property (@(posedge ref_clk) disable iff (rst)
      load_out && addr_last && shin_next == `ADDR_DEVICE_FIRST && !hw_reset
      |=> shout_q == DEVICE_ID)
      else $error("address one did not put device byte first");

   a_bytes_alternate: assert property (@(posedge ref_clk) disable iff (rst)
      sclk_fall && state_q == ST_OUT && kind_q == OUT_MAKER && last_out && !hw_reset
      |=> byte_sel_q != $past(byte_sel_q))
      else $error("maker and device bytes do not alternate");

   a_signature_repeats: assert property (@(posedge ref_clk) disable iff (rst)
      sclk_fall && state_q == ST_OUT && kind_q == OUT_SIG && last_out && !hw_reset
      |=> shout_q == SIGNATURE_ID)
      else $error("signature byte not repeated");

   a_release_delayed: assert property (@(posedge ref_clk) disable iff (rst)
      exec_release && deep_powerdown && !hw_reset
      |=> !standby ##0 (1'b1 ##[1:REC_BOUND] !deep_powerdown))
      else $error("release recovery not observed");

   c_latch_set: cover property (@(posedge ref_clk) disable iff (rst) exec_set);
   c_maker_read: cover property (@(posedge ref_clk) disable iff (rst)
      sclk_fall && state_q == ST_OUT && kind_q == OUT_MAKER && last_out);
   c_release_wake: cover property (@(posedge ref_clk) disable iff (rst)
      exec_release && deep_powerdown);
   c_quad_signature: cover property (@(posedge ref_clk) disable iff (rst)
      drive_q && quad_q);

endmodule : write_latch_and_id_commands

// ==== tb/flash_host_model.sv ====
// Host flash controller model for the serial link
`timescale 1ns/100ps
module flash_host_model (
   input wire logic ref_clk, // bench clock
   input wire logic [3:0] sio_out, // device data lines
   input wire logic [3:0] sio_oe_n, // device enables, low drives
   output logic cs_n, // chip select
   output logic sclk, // serial clock
   output logic [3:0] sio_in, // resolved data lines
   output logic [7:0] rx_byte, // byte read back
   output logic rx_valid // pulse per byte read back
);
   logic [3:0] host_drv;
   // ************************************************
   // Line resolution
   // ************************************************
   // Device wins where it drives; elsewhere the host level or its float pattern
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         sio_in[i] = (sio_oe_n[i] == 1'b0) ? sio_out[i] : host_drv[i];
      end
   end
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      host_drv = 4'h5;
      rx_byte = 8'h00;
      rx_valid = 1'b0;
   end
   // ************************************************
   // Link tasks
   // ************************************************
   task automatic select();
      cs_n = 1'b0;
      repeat (2) @(negedge ref_clk);
   endtask : select
   // Host may end any read here, also mid-byte
   task automatic deselect();
      cs_n = 1'b1;
      host_drv = ~host_drv;
   endtask : deselect
   // One serial clock period; sample just before the falling edge
   task automatic unit(input logic [3:0] val, output logic [3:0] seen);
      host_drv = val;
      repeat (4) @(negedge ref_clk);
      sclk = 1'b1;
      repeat (3) @(negedge ref_clk);
      seen = sio_in;
      @(negedge ref_clk);
      sclk = 1'b0;
   endtask : unit
   task automatic send_byte(input logic [7:0] b, input bit quad);
      logic [3:0] s;
      logic [2:0] junk;
      if (quad) begin
         unit(b[7:4], s);
         unit(b[3:0], s);
      end else begin
         for (int i = 7; i >= 0; i--) begin
            junk = 3'($urandom);
            unit({junk, b[i]}, s);
         end
      end
   endtask : send_byte
   // Released lines toggle every clock while the device answers
   task automatic recv_byte(input bit quad, input bit report, output logic [7:0] b);
      logic [3:0] s;
      for (int i = 0; i < (quad ? 2 : 8); i++) begin
         unit(~host_drv, s);
         b = quad ? {b[3:0], s} : {b[6:0], s[1]};
      end
      if (report) begin
         rx_byte = b;
         rx_valid = 1'b1;
         @(negedge ref_clk);
         rx_valid = 1'b0;
      end
   endtask : recv_byte
endmodule : flash_host_model

// ==== tb/tb_write_latch_and_id_commands.sv ====
// Self-checking bench for the write latch and identification commands
`timescale 1ns/100ps
`include "flash_cmd_consts.svh"
module tb_write_latch_and_id_commands;
   localparam int unsigned REC = 10;
   localparam logic [7:0] MK = 8'hA5; // arbitrary value
   localparam logic [7:0] TY = 8'h3C; // arbitrary value
   localparam logic [7:0] DN = 8'h21; // arbitrary value
   localparam logic [7:0] SG = 8'h6E; // arbitrary value
   localparam logic [7:0] DV = 8'h93; // arbitrary value
   logic ref_clk, rst, cs_n, sclk, reset_pin_n, quad_command_mode, operation_busy_flag;
   logic write_op_done, soft_reset_done, powerdown_enter, latch, dpd, standby, rx_valid;
   logic [3:0] sio_in, sio_out, sio_oe_n, s;
   logic [1:0] status_low;
   logic [7:0] rx_byte;
   logic [7:0] exp_q[$];
   int fail_count, comparisons, n;
   write_latch_and_id_commands #(.MAKER_ID(MK), .MEM_TYPE(TY), .MEM_DENSITY(DN),
      .SIGNATURE_ID(SG), .DEVICE_ID(DV), .RECOVERY_CYC(REC)) i_dut (.ref_clk(ref_clk),
      .rst(rst), .cs_n(cs_n), .sclk(sclk), .sio_in(sio_in), .sio_out(sio_out),
      .sio_oe_n(sio_oe_n), .reset_pin_n(reset_pin_n), .quad_command_mode(quad_command_mode),
      .operation_busy_flag(operation_busy_flag), .write_op_done(write_op_done),
      .soft_reset_done(soft_reset_done), .powerdown_enter(powerdown_enter),
      .write_permission_latch(latch), .status_low(status_low), .deep_powerdown(dpd),
      .standby(standby));
   flash_host_model p (.ref_clk(ref_clk), .sio_out(sio_out), .sio_oe_n(sio_oe_n),
      .cs_n(cs_n), .sclk(sclk), .sio_in(sio_in), .rx_byte(rx_byte), .rx_valid(rx_valid));
   initial ref_clk = 1'b0;
   always #50 ref_clk = ~ref_clk;
   // ************************************************
   // Checking and reporting
   // ************************************************
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report
   // Oldest note against each byte the host reads back
   always @(posedge ref_clk) begin
      if (rx_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("unexpected byte", {8'h00, rx_byte}, 16'hFFFF);
         end else begin
            check("read byte", {8'h00, rx_byte}, {8'h00, exp_q.pop_front()});
         end
      end
   end
   // ************************************************
   // Stimulus helpers
   // ************************************************
   task automatic gap(input int k);
      repeat (k) @(negedge ref_clk);
   endtask : gap
   // Address phase: dummy bytes are random, the last byte is the address
   task automatic cmd(input logic [7:0] op, input bit quad, input int n_addr,
         input logic [7:0] addr, input int n_rd, input bit rep);
      logic [7:0] d;
      p.select();
      p.send_byte(op, quad);
      for (int i = 0; i < n_addr; i++) begin
         d = (i == n_addr - 1) ? addr : 8'($urandom);
         p.send_byte(d, quad);
      end
      for (int i = 0; i < n_rd; i++) begin
         p.recv_byte(quad, rep, d);
      end
      if (n_rd > 0) begin
         check("enable in read", 16'(sio_oe_n),
            16'(!rep ? `OE_OFF : (quad ? `OE_QUAD : `OE_SINGLE)));
      end
      p.deselect();
      gap(10);
      check("enable after deselect", 16'(sio_oe_n), 16'(`OE_OFF));
   endtask : cmd
   // ************************************************
   // Main sequence
   // ************************************************
   initial begin
      {rst, reset_pin_n} = 2'b11;
      {quad_command_mode, operation_busy_flag, write_op_done} = 3'b000;
      {soft_reset_done, powerdown_enter} = 2'b00;
      fail_count = 0;
      comparisons = 0;
      void'($urandom(15303));
      gap(16);
      rst = 1'b0;
      gap(6);
      check("latch after reset", 16'(latch), 16'h0000);
      check("powerdown after reset", 16'(dpd), 16'h0000);
      for (int m = 0; m < 2; m++) begin
         quad_command_mode = m[0];
         gap(2);
         cmd(`OPC_LATCH_SET, m[0], 0, 8'h00, 0, 0);
         check("latch set", 16'(latch), 16'h0001);
         check("status bit one", 16'(status_low[1]), 16'h0001);
         cmd(`OPC_LATCH_CLEAR, m[0], 0, 8'h00, 0, 0);
         check("latch clear", 16'(latch), 16'h0000);
      end
      quad_command_mode = 1'b0;
      p.select();
      p.send_byte(`OPC_LATCH_SET, 1'b0);
      p.unit(4'h0, s);
      p.deselect();
      gap(10);
      check("set with extra clock", 16'(latch), 16'h0000);
      p.select();
      for (int i = 7; i >= 3; i--) p.unit({3'b000, 1'(`OPC_LATCH_SET >> i)}, s);
      p.deselect();
      gap(10);
      check("set cut short", 16'(latch), 16'h0000);
      for (int e = 0; e < 3; e++) begin
         cmd(`OPC_LATCH_SET, 1'b0, 0, 8'h00, 0, 0);
         case (e)
            0: write_op_done = 1'b1;
            1: soft_reset_done = 1'b1;
            default: reset_pin_n = 1'b0;
         endcase
         gap(e == 2 ? 8 : 1);
         {write_op_done, soft_reset_done, reset_pin_n} = 3'b001;
         gap(8);
         check("latch after clear event", 16'(latch), 16'h0000);
      end
      exp_q = '{MK, TY, DN, MK};
      cmd(`OPC_IDENT_READ, 1'b0, 0, 8'h00, 4, 1);
      p.select();
      p.send_byte(`OPC_IDENT_READ, 1'b0);
      for (int i = 0; i < 3; i++) p.unit(4'h0, s);
      p.deselect();
      gap(8);
      check("enable after early end", 16'(sio_oe_n), 16'(`OE_OFF));
      exp_q = '{SG, SG};
      cmd(`OPC_SIGNATURE, 1'b0, 0, 8'h00, 2, 1);
      quad_command_mode = 1'b1;
      gap(2);
      exp_q = '{SG, SG};
      cmd(`OPC_SIGNATURE, 1'b1, 0, 8'h00, 2, 1);
      cmd(`OPC_IDENT_READ, 1'b1, 0, 8'h00, 1, 0);
      quad_command_mode = 1'b0;
      for (int a = 0; a < 2; a++) begin
         exp_q = '{a ? DV : MK, a ? MK : DV, a ? DV : MK};
         cmd(`OPC_MAKER_DEV, 1'b0, 3, 8'(a), 3, 1);
      end
      operation_busy_flag = 1'b1;
      gap(2);
      cmd(`OPC_IDENT_READ, 1'b0, 0, 8'h00, 1, 0);
      cmd(`OPC_LATCH_SET, 1'b0, 0, 8'h00, 0, 0);
      check("set while busy", 16'(latch), 16'h0000);
      check("standby while busy", 16'(standby), 16'h0000);
      check("status busy bit", 16'(status_low[0]), 16'h0001);
      operation_busy_flag = 1'b0;
      gap(2);
      p.select();
      p.send_byte(`OPC_SIGNATURE, 1'b0);
      p.deselect();
      gap(6);
      check("standby after release", 16'(standby), 16'h0001);
      powerdown_enter = 1'b1;
      gap(1);
      powerdown_enter = 1'b0;
      gap(4);
      check("powerdown entered", 16'(dpd), 16'h0001);
      cmd(`OPC_IDENT_READ, 1'b0, 0, 8'h00, 1, 0);
      p.select();
      p.send_byte(`OPC_SIGNATURE, 1'b0);
      p.deselect();
      gap(8);
      check("release still waiting", 16'(dpd), 16'h0001);
      n = 0;
      while (dpd !== 1'b0 && n < 40) begin
         gap(1);
         n++;
      end
      if (n >= 40) begin
         fail_count++;
         final_report();
      end
      check("release delay", 16'(n + 8 >= REC + 3 && n + 8 <= REC + 7), 16'h0001);
      check("standby after recovery", 16'(standby), 16'h0001);
      gap(REC);
      powerdown_enter = 1'b1;
      gap(1);
      powerdown_enter = 1'b0;
      gap(4);
      reset_pin_n = 1'b0;
      gap(8);
      reset_pin_n = 1'b1;
      gap(6);
      check("powerdown after reset pin", 16'(dpd), 16'h0000);
      check("bytes left unread", 16'(exp_q.size()), 16'h0000);
      final_report();
   end
endmodule : tb_write_latch_and_id_commands
